// ### design/dac_ctrl_pkg.sv
// package: register map, field positions, reset values, bus answers and the channel output type for the dual converter control
//
// Functional notes
// - control bit 7 picks 8-bit mode (1) or 12-bit mode (0) for both channels
// - in 8-bit mode one write to the low data register gives the whole code
// - control bit 6: channel 1 range, 1 zero-to-supply, 0 zero-to-reference
// - control bit 5: channel 0 range, same encoding as channel 1
// - bits 4 and 3 low force channel 1 and 0 codes to zero
// - with sync bit 2 high, writing a low data register updates that channel at once
// - with sync bit low writes are held; setting it moves both codes together
// - bits 1 and 0 power channel 1 and channel 0 on when high
// - after reset both channels are off with outputs high-impedance
// - 12-bit code right-justified: low register bits 7:0, high nibble bits 11:8
// - buffer bypass routes output around the buffer, only on the reference range
// - configuration bit 5 high bypasses the output buffer, low enables it
package dac_ctrl_pkg;
	// register byte addresses (printed offsets are register indices)
	localparam logic [7:0] IDX_CODE0_LOW = 8'hF9;
	localparam logic [7:0] IDX_CODE0_HIGH = 8'hFA;
	localparam logic [7:0] IDX_CODE1_LOW = 8'hFB;
	localparam logic [7:0] IDX_CODE1_HIGH = 8'hFC;
	localparam logic [7:0] IDX_CONTROL = 8'hFD;
	localparam logic [7:0] IDX_CHIP_CONFIG = 8'hFE;
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CODE0_LOW = {2'h0, IDX_CODE0_LOW, 2'h0};
	localparam logic [11:0] ADDR_CODE0_HIGH = {2'h0, IDX_CODE0_HIGH, 2'h0};
	localparam logic [11:0] ADDR_CODE1_LOW = {2'h0, IDX_CODE1_LOW, 2'h0};
	localparam logic [11:0] ADDR_CODE1_HIGH = {2'h0, IDX_CODE1_HIGH, 2'h0};
	localparam logic [11:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_CHIP_CONFIG = {2'h0, IDX_CHIP_CONFIG, 2'h0};
	// control and configuration field positions
	localparam int BIT_MODE8 = 7;
	localparam int BIT_RANGE1 = 6;
	localparam int BIT_RANGE0 = 5;
	localparam int BIT_FZ1_N = 4;
	localparam int BIT_FZ0_N = 3;
	localparam int BIT_SYNC = 2;
	localparam int BIT_PWR1 = 1;
	localparam int BIT_PWR0 = 0;
	localparam int BIT_BYPASS = 5;
	// reset values
	localparam logic [7:0] RST_CODE = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h04;
	localparam logic [7:0] RST_CHIP_CONFIG = 8'h00;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// state of one converter channel as seen by the analog core
	typedef struct packed {
		logic [11:0] code;
		logic range_supply;
		logic enable;
		logic buffer_bypass;
	} chan_out_t;
endpackage

// ### design/dual_dac_register_control.sv
// module: AXI4-Lite register slave and code latching for two 12-bit converters
`timescale 1ns/1ps
module dual_dac_register_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output dac_ctrl_pkg::chan_out_t chan0,
	output dac_ctrl_pkg::chan_out_t chan1
);
	logic [7:0] code0_low_r;
	logic [7:0] code0_high_r;
	logic [7:0] code1_low_r;
	logic [7:0] code1_high_r;
	logic [7:0] control_r;
	logic [7:0] config_r;
	logic [11:0] live0_r;
	logic [11:0] live1_r;
	logic [11:0] aw_addr_r;
	logic aw_held_r;
	logic [31:0] w_data_r;
	logic w_strb0_r;
	logic w_held_r;
	logic do_write;
	logic do_read;

	// true when an address names one of the mapped registers
	function automatic logic is_mapped(input logic [11:0] a);
		return a == dac_ctrl_pkg::ADDR_CODE0_LOW || a == dac_ctrl_pkg::ADDR_CODE0_HIGH ||
			a == dac_ctrl_pkg::ADDR_CODE1_LOW || a == dac_ctrl_pkg::ADDR_CODE1_HIGH ||
			a == dac_ctrl_pkg::ADDR_CONTROL || a == dac_ctrl_pkg::ADDR_CHIP_CONFIG;
	endfunction

	// compose the 12-bit code of a channel from its data registers
	function automatic logic [11:0] code_of(input logic mode8, input logic [7:0] lo,
		input logic [7:0] hi);
		if (mode8) begin
			return {4'h0, lo};
		end
		return {hi[3:0], lo};
	endfunction

	// address and data are taken in either order, once each, until the response goes
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;

	// capture of the write address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_r <= 1'b0;
		end
	end

	// capture of the write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb0_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb0_r <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_held_r <= 1'b0;
		end
	end

	// write response, error for unmapped addresses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dac_ctrl_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(aw_addr_r) ? dac_ctrl_pkg::RESP_OKAY
				: dac_ctrl_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register storage; only byte lane 0 carries data, clear and power-down keep codes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			code0_low_r <= dac_ctrl_pkg::RST_CODE;
			code0_high_r <= dac_ctrl_pkg::RST_CODE;
			code1_low_r <= dac_ctrl_pkg::RST_CODE;
			code1_high_r <= dac_ctrl_pkg::RST_CODE;
			control_r <= dac_ctrl_pkg::RST_CONTROL;
			config_r <= dac_ctrl_pkg::RST_CHIP_CONFIG;
		end else if (do_write && w_strb0_r) begin
			case (aw_addr_r)
				dac_ctrl_pkg::ADDR_CODE0_LOW: code0_low_r <= w_data_r[7:0];
				dac_ctrl_pkg::ADDR_CODE0_HIGH: code0_high_r <= w_data_r[7:0];
				dac_ctrl_pkg::ADDR_CODE1_LOW: code1_low_r <= w_data_r[7:0];
				dac_ctrl_pkg::ADDR_CODE1_HIGH: code1_high_r <= w_data_r[7:0];
				dac_ctrl_pkg::ADDR_CONTROL: control_r <= w_data_r[7:0];
				dac_ctrl_pkg::ADDR_CHIP_CONFIG: config_r <= w_data_r[7:0];
				default: config_r <= config_r;
			endcase
		end
	end

	// latched codes that drive the converters
	always_ff @(posedge aclk) begin
		logic mode8;
		logic sync_now;
		logic sync_rise;
		mode8 = w_data_r[dac_ctrl_pkg::BIT_MODE8];
		sync_now = control_r[dac_ctrl_pkg::BIT_SYNC];
		sync_rise = 1'b0;
		if (!aresetn) begin
			live0_r <= 12'h000;
			live1_r <= 12'h000;
		end else if (do_write && w_strb0_r) begin
			mode8 = control_r[dac_ctrl_pkg::BIT_MODE8];
			if (aw_addr_r == dac_ctrl_pkg::ADDR_CONTROL) begin
				mode8 = w_data_r[dac_ctrl_pkg::BIT_MODE8];
				sync_rise = !sync_now && w_data_r[dac_ctrl_pkg::BIT_SYNC];
			end
			if (sync_rise) begin
				live0_r <= code_of(mode8, code0_low_r, code0_high_r);
				live1_r <= code_of(mode8, code1_low_r, code1_high_r);
			end else if (sync_now && aw_addr_r == dac_ctrl_pkg::ADDR_CODE0_LOW) begin
				live0_r <= code_of(mode8, w_data_r[7:0], code0_high_r);
			end else if (sync_now && aw_addr_r == dac_ctrl_pkg::ADDR_CODE1_LOW) begin
				live1_r <= code_of(mode8, w_data_r[7:0], code1_high_r);
			end
		end
	end

	// read channel; unmapped reads return zero with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= dac_ctrl_pkg::RESP_OKAY;
		end else if (do_read) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? dac_ctrl_pkg::RESP_OKAY
				: dac_ctrl_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				dac_ctrl_pkg::ADDR_CODE0_LOW: s_axi_rdata <= {24'h000000, code0_low_r};
				dac_ctrl_pkg::ADDR_CODE0_HIGH: s_axi_rdata <= {24'h000000, code0_high_r};
				dac_ctrl_pkg::ADDR_CODE1_LOW: s_axi_rdata <= {24'h000000, code1_low_r};
				dac_ctrl_pkg::ADDR_CODE1_HIGH: s_axi_rdata <= {24'h000000, code1_high_r};
				dac_ctrl_pkg::ADDR_CONTROL: s_axi_rdata <= {24'h000000, control_r};
				dac_ctrl_pkg::ADDR_CHIP_CONFIG: s_axi_rdata <= {24'h000000, config_r};
				default: s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// outputs to the analog cores; force-zero masks code only, stored value survives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan0 <= '0;
			chan1 <= '0;
		end else begin
			chan0.code <= control_r[dac_ctrl_pkg::BIT_FZ0_N] ? live0_r : 12'h000;
			chan1.code <= control_r[dac_ctrl_pkg::BIT_FZ1_N] ? live1_r : 12'h000;
			chan0.range_supply <= control_r[dac_ctrl_pkg::BIT_RANGE0];
			chan1.range_supply <= control_r[dac_ctrl_pkg::BIT_RANGE1];
			chan0.enable <= control_r[dac_ctrl_pkg::BIT_PWR0];
			chan1.enable <= control_r[dac_ctrl_pkg::BIT_PWR1];
			// bypass is honoured only on the reference range
			chan0.buffer_bypass <= config_r[dac_ctrl_pkg::BIT_BYPASS] &&
				!control_r[dac_ctrl_pkg::BIT_RANGE0];
			chan1.buffer_bypass <= config_r[dac_ctrl_pkg::BIT_BYPASS] &&
				!control_r[dac_ctrl_pkg::BIT_RANGE1];
		end
	end
endmodule

// ### tb/dual_dac_register_control_assertions.sv
// checker: bus handshake and channel output relations
`timescale 1ns/1ps
module dual_dac_register_control_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire dac_ctrl_pkg::chan_out_t chan0,
	input wire dac_ctrl_pkg::chan_out_t chan1
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// joint handshake answers two edges later
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write answer dropped");
	a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read answer dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during answer");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read upper bits set");
	// bypass only on the reference range
	a_bypass_chan0: assert property (chan0.range_supply |-> !chan0.buffer_bypass)
		else $error("channel 0 bypass on supply range");
	a_bypass_chan1: assert property (chan1.range_supply |-> !chan1.buffer_bypass)
		else $error("channel 1 bypass on supply range");
endmodule

// ### tb/dual_dac_register_control_test.sv
// testbench: register access and channel output checks for the dual converter control
`timescale 1ns/1ps
module dual_dac_register_control_test;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0, rd, d;
	logic [1:0] bresp, rresp, r;
	logic awr, wrd, bv, arr, rv;
	dac_ctrl_pkg::chan_out_t c0, c1;
	int failures = 0, n_tests = 0, cycles = 0;
	typedef struct packed {logic [11:0] a; logic [7:0] d; logic [1:0] r;} row_t;
	// byte address, reset value, response; 12'h000 is unmapped
	row_t rows [7] = '{'{12'h3E4, 8'h00, 2'h0}, '{12'h3E8, 8'h00, 2'h0},
		'{12'h3EC, 8'h00, 2'h0}, '{12'h3F0, 8'h00, 2'h0}, '{12'h3F4, 8'h04, 2'h0},
		'{12'h3F8, 8'h00, 2'h0}, '{12'h000, 8'h00, 2'h2}};
	always #4 aclk = ~aclk;
	dual_dac_register_control i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .chan0(c0), .chan1(c1));
	task automatic complete_run;
		if (failures == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			complete_run;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one write, then let the channel outputs settle; handshakes judged on settled values
	task automatic wreg(input logic [11:0] a, input logic [7:0] v);
		logic hs;
		logic ta;
		logic tw;
		@(posedge aclk);
		awa <= a;
		wd <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(negedge aclk);
			hs = bv;
			r = bresp;
			ta = awr;
			tw = wrd;
			@(posedge aclk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!hs);
		br <= 1'b0;
		repeat (2) @(posedge aclk);
		#1;
	endtask
	// one read; address released once taken, data taken while it stands
	task automatic rreg(input logic [11:0] a);
		logic hs;
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(negedge aclk);
			hs = arr;
			@(posedge aclk);
		end while (!hs);
		arv <= 1'b0;
		do begin
			@(negedge aclk);
			hs = rv;
			d = rd;
			r = rresp;
			@(posedge aclk);
		end while (!hs);
		rr <= 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		check(c0, 15'h0);
		check(c1, 15'h0);
		foreach (rows[i]) begin
			rreg(rows[i].a);
			check(d, rows[i].d);
			check(r, rows[i].r);
		end
		wreg(12'h3F4, 8'h1F);
		wreg(12'h3E8, 8'h0A);
		wreg(12'h3E4, 8'hBC);
		check(c0.code, 12'hABC);
		check(c0.enable, 1'b1);
		wreg(12'h3E8, 8'h05);
		check(c0.code, 12'hABC);
		wreg(12'h3E4, 8'h12);
		check(c0.code, 12'h512);
		wreg(12'h3F4, 8'h1B);
		wreg(12'h3F0, 8'h03);
		wreg(12'h3EC, 8'h45);
		check(c1.code, 12'h000);
		wreg(12'h3F4, 8'h1F);
		check(c1.code, 12'h345);
		check(c0.code, 12'h512);
		wreg(12'h3F4, 8'h17);
		check(c0.code, 12'h000);
		check(c1.code, 12'h345);
		wreg(12'h3F4, 8'h0F);
		check(c0.code, 12'h512);
		check(c1.code, 12'h000);
		wreg(12'h3F4, 8'h1E);
		check(c0.enable, 1'b0);
		check(c1.enable, 1'b1);
		wreg(12'h3F4, 8'h5F);
		check(c1.range_supply, 1'b1);
		check(c0.range_supply, 1'b0);
		wreg(12'h3F8, 8'h20);
		check(c0.buffer_bypass, 1'b1);
		check(c1.buffer_bypass, 1'b0);
		wreg(12'h3F4, 8'h9F);
		wreg(12'h3E4, 8'h77);
		check(c0.code, 12'h077);
		wreg(12'h000, 8'h55);
		check(r, 2'h2);
		complete_run;
	end
endmodule
bind dual_dac_register_control dual_dac_register_control_assertions i_chk (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .chan0(chan0), .chan1(chan1));
